// ### hdl/psram_burst_pkg.sv
// constants and bundled signal types of the synchronous burst memory port
package psram_burst_pkg;
  localparam int data_w = 16;
  localparam int addr_w = 21;
  localparam int lat_w = 4;
  localparam int len_w = 5;
  localparam logic [lat_w-1:0] latency_dflt = 4'h5;
  localparam logic [len_w-1:0] burst_len_dflt = 5'h04;
  localparam logic [lat_w-1:0] lat_one = 4'h1;
  localparam logic [len_w-1:0] beat_one = 5'h01;
  localparam logic [len_w-1:0] beat_zero = 5'h00;
  localparam int burst_cycle_time_limit_ns = 2500;
  localparam int clk_period_ns = 10;
  localparam int burst_cycle_limit_cyc = burst_cycle_time_limit_ns / clk_period_ns;

  typedef struct packed {
    logic chip_select_n;
    logic address_valid_n;
    logic write_enable_n;
    logic output_enable_n;
    logic upper_byte_enable_n;
    logic lower_byte_enable_n;
  } ctrl_pins_t;

  typedef enum logic [1:0] {
    st_idle,
    st_latency,
    st_data,
    st_done
  } burst_state_t;
endpackage : psram_burst_pkg

// ### hdl/psram_sync_burst_access.sv
// memory-side synchronous burst read/write access port
`timescale 1ns/10ps
module psram_sync_burst_access #(
  parameter int mem_addr_w = 10, // implemented store depth bits
  parameter logic [psram_burst_pkg::lat_w-1:0] latency = psram_burst_pkg::latency_dflt,
  parameter logic [psram_burst_pkg::len_w-1:0] burst_len = psram_burst_pkg::burst_len_dflt
) (
  input wire logic clk, // burst clock
  input wire logic rst, // synchronous reset, high active
  input wire psram_burst_pkg::ctrl_pins_t pins_in, // control pins from controller
  input wire logic [psram_burst_pkg::addr_w-1:0] address, // burst start address
  input wire logic [psram_burst_pkg::data_w-1:0] dq_in, // data pins in
  output logic [psram_burst_pkg::data_w-1:0] dq_out, // data pins out
  output logic dq_oe, // data pins driven
  output logic wait_out, // high = ready; read data reach the pins two clocks later
  output logic wait_oe // wait pin driven
);
  // ======================================================
  // input synchronisers
  psram_burst_pkg::ctrl_pins_t pins_m, pins_s, pins_p;
  logic [psram_burst_pkg::addr_w-1:0] addr_m, addr_s;
  logic [psram_burst_pkg::data_w-1:0] dq_m, dq_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      pins_m <= '1;
      pins_s <= '1;
      pins_p <= '1;
    end else begin
      pins_m <= pins_in;
      pins_s <= pins_m;
      pins_p <= pins_s;
    end
  end

  // every answer lags the pads by these two stages; address and data need no
  // reset since they are only looked at under a synced strobe or beat
  always_ff @(posedge clk) begin
    addr_m <= address;
    addr_s <= addr_m;
  end

  always_ff @(posedge clk) begin
    dq_m <= dq_in;
    dq_s <= dq_m;
  end

  logic selected, strobe_fall, cs_fall;
  assign selected = !pins_s.chip_select_n;
  // only the first edge of a low strobe starts a burst; later edges are ignored
  assign strobe_fall = selected && !pins_s.address_valid_n && pins_p.address_valid_n;
  assign cs_fall = selected && pins_p.chip_select_n;

  // ======================================================
  // burst sequencer
  psram_burst_pkg::burst_state_t state_q;
  logic [psram_burst_pkg::lat_w-1:0] lat_cnt_q;
  logic [psram_burst_pkg::len_w-1:0] beat_q;
  logic [mem_addr_w-1:0] addr_q;
  logic is_write_q;
  logic start;

  // beat decode is shared by the counters, the store and the pin drivers
  function automatic logic in_data(input psram_burst_pkg::burst_state_t s);
    return s == psram_burst_pkg::st_data;
  endfunction : in_data

  // last latency count: ready is raised here, on the same clock edge that starts the first beat
  function automatic logic lat_ends(input logic [psram_burst_pkg::lat_w-1:0] c);
    return c == psram_burst_pkg::lat_one;
  endfunction : lat_ends

  // a new strobe is taken only from idle or after the last beat
  assign start = strobe_fall && (state_q == psram_burst_pkg::st_idle ||
                                 state_q == psram_burst_pkg::st_done);

  // deselect drops a burst at once; a cut burst leaves nothing pending
  always_ff @(posedge clk) begin
    if (rst || !selected) begin
      state_q <= psram_burst_pkg::st_idle;
    end else if (start) begin
      state_q <= psram_burst_pkg::st_latency;
    end else begin
      case (state_q)
        psram_burst_pkg::st_latency: begin
          if (lat_ends(lat_cnt_q)) begin
            state_q <= psram_burst_pkg::st_data;
          end
        end
        psram_burst_pkg::st_data: begin
          if (beat_q == burst_len - psram_burst_pkg::beat_one) begin
            state_q <= psram_burst_pkg::st_done;
          end
        end
        psram_burst_pkg::st_idle: state_q <= psram_burst_pkg::st_idle;
        psram_burst_pkg::st_done: state_q <= psram_burst_pkg::st_done;
        default: state_q <= psram_burst_pkg::st_idle;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lat_cnt_q <= '0;
    end else if (start) begin
      lat_cnt_q <= latency - psram_burst_pkg::lat_one;
    end else if (state_q == psram_burst_pkg::st_latency) begin
      lat_cnt_q <= lat_cnt_q - psram_burst_pkg::lat_one;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || start) begin
      beat_q <= psram_burst_pkg::beat_zero;
    end else if (in_data(state_q)) begin
      beat_q <= beat_q + psram_burst_pkg::beat_one;
    end
  end

  // linear burst: the address just climbs, no wrap at the burst length
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_q <= '0;
    end else if (start) begin
      addr_q <= addr_s[mem_addr_w-1:0];
    end else if (in_data(state_q)) begin
      addr_q <= addr_q + mem_addr_w'(1);
    end
  end

  // direction is latched at the strobe and kept for the whole burst
  always_ff @(posedge clk) begin
    if (rst) begin
      is_write_q <= 1'b0;
    end else if (start) begin
      is_write_q <= !pins_s.write_enable_n;
    end
  end

  // ======================================================
  // storage
  logic beat_wr;
  logic [1:0] lanes;
  logic [psram_burst_pkg::data_w-1:0] rd_word;
  localparam logic [1:0] lanes_off = 2'h0;

  assign lanes = {!pins_s.upper_byte_enable_n, !pins_s.lower_byte_enable_n};
  // both lanes off leaves the word untouched for that beat
  assign beat_wr = in_data(state_q) && is_write_q && (lanes != lanes_off);

  psram_word_mem #(
    .addr_w(mem_addr_w),
    .data_w(psram_burst_pkg::data_w)
  ) u_mem (
    .clk(clk),
    .wr_en(beat_wr),
    .byte_en(lanes),
    .wr_addr(addr_q),
    .wr_data(dq_s),
    .rd_addr(addr_q),
    .rd_data(rd_word)
  );

  // ======================================================
  // pin drivers
  // read data lag the beat by two clocks: store register, then pin register
  logic rd_beat_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_beat_q <= 1'b0;
    end else begin
      rd_beat_q <= in_data(state_q) && !is_write_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dq_out <= '0;
    end else if (rd_beat_q) begin
      dq_out <= rd_word;
    end
  end

  // last data is held while output enable stays low
  always_ff @(posedge clk) begin
    if (rst) begin
      dq_oe <= 1'b0;
    end else begin
      dq_oe <= selected && !pins_s.output_enable_n && !is_write_q &&
               (rd_beat_q || state_q == psram_burst_pkg::st_done);
    end
  end

  // the pin is let go as soon as the synced select is high; wait_out is
  // cleared low at the same clock and then means nothing to the controller
  always_ff @(posedge clk) begin
    if (rst || !selected) begin
      wait_oe <= 1'b0;
    end else begin
      wait_oe <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !selected) begin
      wait_out <= 1'b0;
    end else begin
      if (cs_fall || start) begin
        wait_out <= 1'b0;
      end else if (state_q == psram_burst_pkg::st_latency && lat_ends(lat_cnt_q)) begin
        wait_out <= 1'b1;
      end
    end
  end
endmodule : psram_sync_burst_access

// ### hdl/psram_word_mem.sv
// word store with per-byte write and registered read data
`timescale 1ns/10ps
module psram_word_mem #(
  parameter int addr_w = 8,
  parameter int data_w = 16
) (
  input wire logic clk, // clock
  input wire logic wr_en, // write strobe
  input wire logic [1:0] byte_en, // byte lanes, high active
  input wire logic [addr_w-1:0] wr_addr, // write address
  input wire logic [data_w-1:0] wr_data, // write data
  input wire logic [addr_w-1:0] rd_addr, // read address
  output logic [data_w-1:0] rd_data // registered read data
);
  logic [data_w-1:0] mem [0:(1<<addr_w)-1];

  always_ff @(posedge clk) begin
    if (wr_en && byte_en[0]) begin
      mem[wr_addr][data_w/2-1:0] <= wr_data[data_w/2-1:0];
    end
    if (wr_en && byte_en[1]) begin
      mem[wr_addr][data_w-1:data_w/2] <= wr_data[data_w-1:data_w/2];
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule : psram_word_mem

// ### verif/host_ctrl_model.sv
// controller model: strobes, write beats, read capture
`timescale 1ns/10ps
module host_ctrl_model (
  input wire logic clk, // clock
  input wire logic wait_out, // ready flag
  input wire logic wait_oe, // wait drive
  input wire logic [15:0] dq_out, // read data
  input wire logic dq_oe, // data drive
  output psram_burst_pkg::ctrl_pins_t pins, // control pins
  output logic [20:0] address, // address
  output logic [15:0] dq_in // write data
);
  // ====
  // beats are timed from the strobe since writes cannot wait for ready
  // the first beat is sampled a full latency after the strobe's first edge
  localparam int lb = psram_burst_pkg::latency_dflt;
  logic [15:0] wd[4];
  logic [15:0] rd[4];
  logic [1:0] be[4];
  int low_cnt;
  logic oe_ok;
  initial begin
    pins = '1;
    address = '0;
    dq_in = '0;
  end
  task automatic burst(input logic wr, input logic [20:0] a, input int hold, input logic keep);
    int r;
    r = 99;
    low_cnt = 0;
    oe_ok = 1'b1;
    @(negedge clk);
    pins = {1'b0, 1'b0, !wr, wr, 2'b00};
    address = a;
    for (int i = 1; i < r + 6 && i < 40; i++) begin
      @(negedge clk);
      if (i == hold) begin
        pins.address_valid_n = 1'b1;
        address = ~a;
      end
      if (wr && i >= lb && i < lb + 4) begin
        dq_in = wd[i-lb];
        {pins.upper_byte_enable_n, pins.lower_byte_enable_n} = be[i-lb];
      end else begin
        dq_in = ~dq_in;
      end
      if (wait_oe === 1'b1 && wait_out === 1'b0 && r == 99) low_cnt++;
      if (wait_oe === 1'b1 && wait_out === 1'b1 && low_cnt > 0 && r == 99) r = i;
      if (i - r >= 2 && i - r < 6) begin
        rd[i-r-2] = dq_out;
        if (dq_oe !== !wr) oe_ok = 1'b0;
      end
    end
    if (r == 99) low_cnt = -1;
    if (!keep) pins = '1;
  endtask : burst
endmodule : host_ctrl_model

// ### verif/psram_burst_properties.sv
// pin timing checker for the synchronous burst port
`timescale 1ns/10ps
module psram_burst_properties #(
  parameter logic [psram_burst_pkg::lat_w-1:0] latency = psram_burst_pkg::latency_dflt
) (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire psram_burst_pkg::ctrl_pins_t pins_in, // control pins
  input wire logic dq_oe, // data drive
  input wire logic wait_out, // ready flag
  input wire logic wait_oe // wait drive
);
  // ====
  // synced view of the pins, two stages like the port itself
  localparam int lr = latency - 1;
  localparam int l2 = latency - 2;
  localparam int lp = latency + 2;
  psram_burst_pkg::ctrl_pins_t p1_q, p2_q, p3_q;
  always_ff @(posedge clk) begin
    p1_q <= rst ? '1 : pins_in;
    p2_q <= rst ? '1 : p1_q;
    p3_q <= rst ? '1 : p2_q;
  end
  logic strobe;
  assign strobe = !p2_q.chip_select_n && !p2_q.address_valid_n && p3_q.address_valid_n;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence held_seq;
    strobe ##1 !p2_q.address_valid_n;
  endsequence
  sequence ready_seq;
    !wait_out ##1 wait_out;
  endsequence
  strobe_low_a: assert property (strobe |-> ##2 (wait_oe && !wait_out))
    else $error("wait not low after strobe");
  sel_low_a: assert property ($fell(p2_q.chip_select_n) |-> ##2 !wait_out)
    else $error("wait not low after select");
  ready_edge_a: assert property (strobe |-> ##lr ready_seq)
    else $error("wait rise misplaced");
  // a one-clock high select is legal, so the release is looked at the next clock
  wait_release_a: assert property ($rose(p2_q.chip_select_n) |-> ##1 !wait_oe)
    else $error("wait not released");
  held_strobe_a: assert property (held_seq |-> ##l2 ready_seq)
    else $error("held strobe restarted burst");
  chained_burst_a: assert property (strobe && !p3_q.chip_select_n |-> ##2 !wait_out ##l2 wait_out)
    else $error("chained burst not taken");
  read_beats_a: assert property (strobe && p2_q.write_enable_n |-> ##lp dq_oe [*4])
    else $error("read beats missing");
  write_quiet_a: assert property (strobe && !p2_q.write_enable_n |-> ##2 !dq_oe [*6])
    else $error("data driven during write");
endmodule : psram_burst_properties
bind psram_sync_burst_access psram_burst_properties #(.latency(latency)) chk (.clk(clk),
  .rst(rst), .pins_in(pins_in), .dq_oe(dq_oe), .wait_out(wait_out), .wait_oe(wait_oe));

// ### verif/tb_psram_sync_burst_access.sv
// testbench of the synchronous burst access port
`timescale 1ns/10ps
module tb_psram_sync_burst_access;
  // ====
  // write, masked rewrite, readback per round
  logic clk = 1'b0;
  logic rst = 1'b1;
  psram_burst_pkg::ctrl_pins_t pins;
  logic [20:0] address, a;
  logic [15:0] dq_in, dq_out;
  logic dq_oe, wait_out, wait_oe;
  logic [15:0] ref_q[64];
  int mismatches = 0;
  int n_tests = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  psram_sync_burst_access #(.mem_addr_w(6)) dut (.clk(clk), .rst(rst), .pins_in(pins),
    .address(address), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .wait_out(wait_out), .wait_oe(wait_oe));
  host_ctrl_model host (.clk(clk), .wait_out(wait_out), .wait_oe(wait_oe),
    .dq_out(dq_out), .dq_oe(dq_oe), .pins(pins), .address(address), .dq_in(dq_in));
  function automatic logic [15:0] merge(logic [15:0] o, logic [15:0] n, logic [1:0] b);
    return {b[1] ? o[15:8] : n[15:8], b[0] ? o[7:0] : n[7:0]};
  endfunction : merge
  task automatic stop_test();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic check(input logic ok);
    n_tests++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("FAIL %0t mismatch", $time);
    end
  endtask : check
  task automatic run(input logic wr, input int hold, input logic keep);
    host.burst(wr, a, hold, keep);
    if (host.low_cnt < 0) begin
      mismatches++;
      $display("FAIL %0t wait never went ready", $time);
      stop_test();
    end else begin
      check(host.low_cnt == psram_burst_pkg::latency_dflt - 1);
      check(host.oe_ok);
    end
  endtask : run
  initial begin
    void'($urandom(18423));
    repeat (20) @(negedge clk);
    rst = 1'b0;
    for (int t = 0; t < 8; t++) begin
      a = 21'($urandom_range(59));
      for (int k = 0; k < 4; k++) begin
        host.wd[k] = 16'($urandom);
        host.be[k] = 2'b00;
        ref_q[a+k] = host.wd[k];
      end
      run(1'b1, 1, t[0]);
      for (int k = 0; k < 4; k++) begin
        host.wd[k] = 16'($urandom);
        host.be[k] = (k == 2) ? 2'b11 : 2'($urandom);
        ref_q[a+k] = merge(ref_q[a+k], host.wd[k], host.be[k]);
      end
      run(1'b1, 1 + t[1], 1'b1);
      run(1'b0, 1 + t[0], 1'b0);
      for (int k = 0; k < 4; k++) check(host.rd[k] === ref_q[a+k]);
      repeat (3) @(negedge clk);
      check(wait_oe === 1'b0 && dq_oe === 1'b0);
      $display("test %0d done", t);
    end
    stop_test();
  end
endmodule : tb_psram_sync_burst_access
